// File: rtl/mdf_regs.svh
// Register offsets, descriptor field positions and reset values of the descriptor engine
`ifndef MDF_REGS_SVH
`define MDF_REGS_SVH
// APB register byte offsets
`define MDF_CTRL_OFS     8'h00
`define MDF_TXBASE_OFS   8'h04
`define MDF_RXBASE_OFS   8'h08
`define MDF_STAT_OFS     8'h0C
`define MDF_MASK_OFS     8'h10
`define MDF_POLL_OFS     8'h14
`define MDF_CURTX_OFS    8'h18
`define MDF_CURRX_OFS    8'h1C
`define MDF_STATE_OFS    8'h20
// Control bits and reset values
`define MDF_CTRL_TXEN    0
`define MDF_CTRL_RXEN    1
`define MDF_CTRL_GIP     2
`define MDF_CTRL_GTCP    3
`define MDF_CTRL_CRC     4
`define MDF_CTRL_RST     5'h00
`define MDF_STAT_RST     4'h0
`define MDF_MASK_RST     4'h0
`define MDF_ADDR_RST     32'h0000_0000
// Status and poll bits
`define MDF_ST_TXDONE    0
`define MDF_ST_RXDONE    1
`define MDF_ST_TXNODESC  2
`define MDF_ST_RXNODESC  3
`define MDF_POLL_TX      0
`define MDF_POLL_RX      1
// Descriptor word offsets and fields
`define MDF_DW1          32'h0000_0004
`define MDF_DW2          32'h0000_0008
`define MDF_DW3          32'h0000_000C
`define MDF_OWN_BIT      31
`define MDF_CMPL_BIT     31
`define MDF_FS_BIT       30
`define MDF_LS_BIT       29
`define MDF_IPCK_BIT     28
`define MDF_TCPCK_BIT    27
`define MDF_UDPCK_BIT    26
`define MDF_WRAP_BIT     25
// Frame layout seen by the checksum logic (word and halfword indices)
`define MDF_ETYPE_WORD   10'h003
`define MDF_TLEN_WORD    10'h004
`define MDF_PROTO_WORD   10'h005
`define MDF_IPCK_WORD    10'h006
`define MDF_UDPCK_WORD   10'h00A
`define MDF_TCPCK_WORD   10'h00C
`define MDF_IP_FIRST_HW  11'h007
`define MDF_IP_LAST_HW   11'h010
`define MDF_IPCK_HW      11'h00C
`define MDF_PSEUDO_HW    11'h00D
`define MDF_TCPCK_HW     11'h019
`define MDF_UDPCK_HW     11'h014
`define MDF_ETYPE_IPV4   16'h0800
`define MDF_VER_IHL_20   8'h45
`define MDF_PROTO_TCP    8'h06
`define MDF_PROTO_UDP    8'h11
`define MDF_IP_HDR_LEN   16'h0014
`endif

// File: rtl/mdf_pkg.sv
// Types and shared arithmetic of the descriptor engine
package mdf_pkg;
  // Engine states
  typedef enum logic [3:0] {
    MDF_IDLE = 4'b0000, MDF_TD0 = 4'b0001, MDF_TD1 = 4'b0010, MDF_TD2 = 4'b0011,
    MDF_TD3  = 4'b0100, MDF_TSUM = 4'b0101, MDF_TRD = 4'b0110, MDF_TOUT = 4'b0111,
    MDF_TWB  = 4'b1000, MDF_RD0 = 4'b1001, MDF_RD1 = 4'b1010, MDF_RD2 = 4'b1011,
    MDF_RD3  = 4'b1100, MDF_RIN = 4'b1101, MDF_RWR = 4'b1110, MDF_RWB = 4'b1111
  } mdf_state_t;

  // End-around carry fold of a ones complement sum
  function automatic logic [15:0] mdf_fold(input logic [31:0] s);
    logic [16:0] t;
    t = {1'b0, s[31:16]} + {1'b0, s[15:0]};
    mdf_fold = t[15:0] + {15'h0000, t[16]};
  endfunction
endpackage

// File: rtl/mdf_engine.sv
// Descriptor engine: transmit and receive ring walker with checksum insertion
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`include "mdf_regs.svh"
module mdf_engine
  import mdf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic      [31:0] tx_data,
  output logic             tx_valid,
  output logic             tx_sof,
  output logic             tx_eof,
  output logic      [2:0]  tx_bytes,
  output logic             tx_crc_append,
  input  wire logic        tx_ready,
  input  wire logic [31:0] rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_last,
  output logic             rx_ready,
  output logic             irq
);

  // Software state
  logic [4:0]  ctrl_reg;     // Enables and global checksum modes
  logic [31:0] txbase_reg;   // Transmit ring start
  logic [31:0] rxbase_reg;   // Receive ring start
  logic [3:0]  stat_reg;     // Sticky events
  logic [3:0]  mask_reg;     // Interrupt enables
  logic        txgo_reg;     // Transmit poll pending
  logic        rxstall_reg;  // Receive ring ran dry
  // Engine state
  mdf_state_t  state_reg;
  mdf_state_t  state_next;
  logic [31:0] txcur_reg;    // Current transmit descriptor
  logic [31:0] rxcur_reg;    // Current receive descriptor
  logic [31:0] tctl_reg;     // Transmit control word
  logic [31:0] tbuf_reg;     // Transmit buffer address
  logic [31:0] tnext_reg;    // Transmit next descriptor
  logic [31:0] rctl_reg;     // Receive control word
  logic [31:0] rbuf_reg;     // Receive buffer address
  logic [31:0] rnext_reg;    // Receive next descriptor
  logic [9:0]  wcnt_reg;     // Word index within buffer
  logic [31:0] rword_reg;    // Received word held for write
  logic        rlast_reg;    // Held word ends the frame
  logic        rfirst_reg;   // Next receive buffer opens a frame
  logic        sum_on_reg;   // Current buffer gets checksum pass
  // Checksum state
  logic [31:0] ipacc_reg;
  logic [31:0] l4acc_reg;
  logic [7:0]  proto_reg;
  logic [15:0] tlen_reg;
  logic        hdr_ok_reg;   // Ethertype IPv4 with 20-byte header
  // Registered outputs
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        mem_req_reg;
  logic        mem_we_reg;
  logic [31:0] mem_addr_reg;
  logic [31:0] mem_wdata_reg;
  logic [31:0] tx_data_reg;
  logic        tx_valid_reg;
  logic        tx_sof_reg;
  logic        tx_eof_reg;
  logic [2:0]  tx_bytes_reg;
  logic        tx_crc_reg;
  logic        rx_ready_reg;
  logic        irq_reg;

  // Ones complement contribution to the IP header sum
  function automatic logic [15:0] ip_part(input logic [10:0] h, input logic [15:0] v);
    ip_part = (h >= `MDF_IP_FIRST_HW && h <= `MDF_IP_LAST_HW && h != `MDF_IPCK_HW) ?
              v : 16'h0000;
  endfunction

  // Contribution to the TCP/UDP sum: addresses, then segment up to the byte count
  function automatic logic [15:0] l4_part(input logic [10:0] h, input logic [15:0] v,
                                          input logic [10:0] cnt, input logic [10:0] skip);
    logic [11:0] b;
    b = {h, 1'b0};
    if (h < `MDF_PSEUDO_HW || h == skip || b >= {1'b0, cnt})
      l4_part = 16'h0000;
    else if (b + 12'h001 == {1'b0, cnt})
      l4_part = {v[15:8], 8'h00};     // Odd last byte padded
    else
      l4_part = v;
  endfunction

  // Halfword to little-endian byte order in a memory word
  function automatic logic [15:0] swap16(input logic [15:0] v);
    swap16 = {v[7:0], v[15:8]};
  endfunction

  // APB decode
  wire        setup_cyc = psel && !penable;
  wire        wr_acc    = psel && penable && pready_reg && pwrite;
  wire        hit_ctrl  = paddr == `MDF_CTRL_OFS;
  wire        hit_txb   = paddr == `MDF_TXBASE_OFS;
  wire        hit_rxb   = paddr == `MDF_RXBASE_OFS;
  wire        hit_stat  = paddr == `MDF_STAT_OFS;
  wire        hit_mask  = paddr == `MDF_MASK_OFS;
  wire        hit_poll  = paddr == `MDF_POLL_OFS;
  wire        hit_curtx = paddr == `MDF_CURTX_OFS;
  wire        hit_currx = paddr == `MDF_CURRX_OFS;
  wire        hit_state = paddr == `MDF_STATE_OFS;
  wire        mapped    = hit_ctrl | hit_txb | hit_rxb | hit_stat | hit_mask | hit_poll |
                          hit_curtx | hit_currx | hit_state;
  wire [31:0] rd_mux    = hit_ctrl  ? {27'h0000000, ctrl_reg} :
                          hit_txb   ? txbase_reg :
                          hit_rxb   ? rxbase_reg :
                          hit_stat  ? {28'h0000000, stat_reg} :
                          hit_mask  ? {28'h0000000, mask_reg} :
                          hit_curtx ? txcur_reg :
                          hit_currx ? rxcur_reg :
                          hit_state ? {28'h0000000, state_reg} : 32'h0000_0000;
  wire        poll_tx   = wr_acc && hit_poll && pwdata[`MDF_POLL_TX];
  wire        poll_rx   = wr_acc && hit_poll && pwdata[`MDF_POLL_RX];

  // Memory handshake and per-state address
  wire        mem_done  = mem_req_reg && mem_ack;
  wire        want_mem  = state_reg != MDF_IDLE && state_reg != MDF_TOUT &&
                          state_reg != MDF_RIN;
  wire [31:0] word_ofs  = {20'h00000, wcnt_reg, 2'b00};
  wire [31:0] addr_mux  = state_reg == MDF_TD1 ? txcur_reg + `MDF_DW1 :
                          state_reg == MDF_TD2 ? txcur_reg + `MDF_DW2 :
                          state_reg == MDF_TD3 ? txcur_reg + `MDF_DW3 :
                          state_reg == MDF_TSUM || state_reg == MDF_TRD ? tbuf_reg + word_ofs :
                          state_reg == MDF_TD0 || state_reg == MDF_TWB ? txcur_reg :
                          state_reg == MDF_RD1 ? rxcur_reg + `MDF_DW1 :
                          state_reg == MDF_RD2 ? rxcur_reg + `MDF_DW2 :
                          state_reg == MDF_RD3 ? rxcur_reg + `MDF_DW3 :
                          state_reg == MDF_RWR ? rbuf_reg + word_ofs : rxcur_reg;
  wire        is_write  = state_reg == MDF_TWB || state_reg == MDF_RWR ||
                          state_reg == MDF_RWB;
  // Receive write-back word: ownership returned, segment marks, byte count
  wire [10:0] rx_count  = {wcnt_reg[8:0], 2'b00};
  wire [31:0] rwb_word  = {1'b0, rfirst_reg, rlast_reg, 18'h00000, rx_count};
  wire [31:0] wdata_mux = state_reg == MDF_RWR ? rword_reg :
                          state_reg == MDF_RWB ? rwb_word : 32'h0000_0000;

  // Transmit descriptor fields
  wire [10:0] tcnt      = tctl_reg[10:0];
  wire [9:0]  tlast_w   = 10'((12'(tcnt) + 12'h003) >> 2) - 10'h001;
  wire        t_fs      = tctl_reg[`MDF_FS_BIT];
  wire        t_ls      = tctl_reg[`MDF_LS_BIT];
  wire        want_ip   = ctrl_reg[`MDF_CTRL_GIP] | tctl_reg[`MDF_IPCK_BIT];
  wire        want_tcp  = ctrl_reg[`MDF_CTRL_GTCP] | tctl_reg[`MDF_TCPCK_BIT];
  wire        want_udp  = tctl_reg[`MDF_UDPCK_BIT];
  // Insert only for a plain 20-byte IPv4 header; TCP also needs ins_ip, and TCP and UDP a matching protocol
  wire        ins_ip    = sum_on_reg && want_ip && hdr_ok_reg;
  wire        ins_tcp   = ins_ip && want_tcp && proto_reg == `MDF_PROTO_TCP;
  wire        ins_udp   = hdr_ok_reg && sum_on_reg && want_udp &&
                          proto_reg == `MDF_PROTO_UDP;
  wire [10:0] l4_skip   = proto_reg == `MDF_PROTO_TCP ? `MDF_TCPCK_HW : `MDF_UDPCK_HW;
  // Final sums; the pseudo header adds protocol and segment length
  wire [15:0] ip_ck     = ~mdf_fold(ipacc_reg);
  wire [31:0] l4_tot    = l4acc_reg + {24'h000000, proto_reg} +
                          {16'h0000, tlen_reg - `MDF_IP_HDR_LEN};
  wire [15:0] l4_raw    = ~mdf_fold(l4_tot);
  wire [15:0] udp_ck    = l4_raw == 16'h0000 ? 16'hFFFF : l4_raw;
  // Checksum pass: both halfwords of the fetched word
  wire [10:0] h0        = {wcnt_reg, 1'b0};
  wire [10:0] h1        = {wcnt_reg, 1'b1};
  wire [15:0] ha        = {mem_rdata[7:0], mem_rdata[15:8]};
  wire [15:0] hb        = {mem_rdata[23:16], mem_rdata[31:24]};
  wire [31:0] ip_add    = {16'h0000, ip_part(h0, ha)} + {16'h0000, ip_part(h1, hb)};
  wire [31:0] l4_add    = {16'h0000, l4_part(h0, ha, tcnt, l4_skip)} +
                          {16'h0000, l4_part(h1, hb, tcnt, l4_skip)};
  // Outgoing word with checksum fields patched in
  wire [31:0] tx_word   =
    ins_ip  && wcnt_reg == `MDF_IPCK_WORD  ? {mem_rdata[31:16], swap16(ip_ck)} :
    ins_tcp && wcnt_reg == `MDF_TCPCK_WORD ? {swap16(l4_raw), mem_rdata[15:0]} :
    ins_udp && wcnt_reg == `MDF_UDPCK_WORD ? {mem_rdata[31:16], swap16(udp_ck)} :
    mem_rdata;
  wire [2:0]  last_bytes = tcnt[1:0] == 2'b00 ? 3'h4 : {1'b0, tcnt[1:0]};
  wire        rx_take   = rx_valid && rx_ready_reg;
  wire        rx_full   = {1'b0, wcnt_reg + 10'h001, 2'b00} >= {2'b00, rctl_reg[10:0]};
  wire [3:0]  stat_set;
  wire [3:0]  stat_next;

  // Event sources; a set in the clearing cycle wins
  assign stat_set[`MDF_ST_TXDONE]   = state_reg == MDF_TWB && mem_done && t_ls &&
                                      tctl_reg[`MDF_CMPL_BIT];
  assign stat_set[`MDF_ST_RXDONE]   = state_reg == MDF_RWB && mem_done && rlast_reg;
  assign stat_set[`MDF_ST_TXNODESC] = state_reg == MDF_TD0 && mem_done &&
                                      !mem_rdata[`MDF_OWN_BIT];
  assign stat_set[`MDF_ST_RXNODESC] = state_reg == MDF_RD0 && mem_done &&
                                      !mem_rdata[`MDF_OWN_BIT];
  assign stat_next = (stat_reg & ~(wr_acc && hit_stat ? pwdata[3:0] : 4'h0)) | stat_set;

  // Next state of the ring walker
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MDF_IDLE: begin
        if (txgo_reg && ctrl_reg[`MDF_CTRL_TXEN])
          state_next = MDF_TD0;
        else if (ctrl_reg[`MDF_CTRL_RXEN] && rx_valid && !rxstall_reg)
          state_next = MDF_RD0;
      end
      // Unowned descriptor parks the ring until the next poll
      MDF_TD0:  if (mem_done) state_next = mem_rdata[`MDF_OWN_BIT] ? MDF_TD1 : MDF_IDLE;
      MDF_TD1:  if (mem_done) state_next = MDF_TD2;
      MDF_TD2:  if (mem_done) state_next = MDF_TD3;
      MDF_TD3: begin
        if (mem_done)
          state_next = tcnt == 11'h000 ? MDF_TWB :
                       (t_fs && (want_ip || want_tcp || want_udp)) ? MDF_TSUM : MDF_TRD;
      end
      MDF_TSUM: if (mem_done && wcnt_reg == tlast_w) state_next = MDF_TRD;
      MDF_TRD:  if (mem_done) state_next = MDF_TOUT;
      MDF_TOUT: if (tx_valid_reg && tx_ready) state_next = wcnt_reg == tlast_w ? MDF_TWB : MDF_TRD;
      MDF_TWB:  if (mem_done) state_next = MDF_TD0;
      MDF_RD0:  if (mem_done) state_next = mem_rdata[`MDF_OWN_BIT] ? MDF_RD1 : MDF_IDLE;
      MDF_RD1:  if (mem_done) state_next = MDF_RD2;
      MDF_RD2:  if (mem_done) state_next = MDF_RD3;
      // Empty buffer is skipped without write-back
      MDF_RD3:  if (mem_done) state_next = rctl_reg[10:0] == 11'h000 ? MDF_RD0 : MDF_RIN;
      MDF_RIN:  if (rx_take) state_next = MDF_RWR;
      MDF_RWR:  if (mem_done) state_next = (rlast_reg || rx_full) ? MDF_RWB : MDF_RIN;
      MDF_RWB:  if (mem_done) state_next = rlast_reg ? MDF_IDLE : MDF_RD0;
      default:  state_next = MDF_IDLE;
    endcase
  end

  // Register file and engine state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_reg    <= `MDF_CTRL_RST;
      txbase_reg  <= `MDF_ADDR_RST;
      rxbase_reg  <= `MDF_ADDR_RST;
      stat_reg    <= `MDF_STAT_RST;
      mask_reg    <= `MDF_MASK_RST;
      txgo_reg    <= 1'b0;
      rxstall_reg <= 1'b0;
      state_reg   <= MDF_IDLE;
    end else begin
      if (wr_acc && hit_ctrl) ctrl_reg <= pwdata[4:0];
      if (wr_acc && hit_txb)  txbase_reg <= pwdata;
      if (wr_acc && hit_rxb)  rxbase_reg <= pwdata;
      if (wr_acc && hit_mask) mask_reg <= pwdata[3:0];
      stat_reg  <= stat_next;
      // Transmit poll wins over the dry-ring clear in the same cycle; on receive the dry-ring set wins over the poll
      txgo_reg    <= poll_tx || (txgo_reg && !stat_set[`MDF_ST_TXNODESC]);
      rxstall_reg <= stat_set[`MDF_ST_RXNODESC] || (rxstall_reg && !poll_rx);
      state_reg <= state_next;
    end
  end

  // Ring pointers; base writes restart the ring
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txcur_reg <= `MDF_ADDR_RST;
      rxcur_reg <= `MDF_ADDR_RST;
    end else begin
      if (wr_acc && hit_txb)
        txcur_reg <= pwdata;
      else if (state_reg == MDF_TWB && mem_done)
        txcur_reg <= tnext_reg;
      if (wr_acc && hit_rxb)
        rxcur_reg <= pwdata;
      else if ((state_reg == MDF_RWB || state_reg == MDF_RD3 && rctl_reg[10:0] == 11'h000)
               && mem_done)
        rxcur_reg <= rctl_reg[`MDF_WRAP_BIT] ? rxbase_reg : rnext_reg;
    end
  end

  // Descriptor words as fetched
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tctl_reg  <= 32'h0000_0000;
      tbuf_reg  <= 32'h0000_0000;
      tnext_reg <= 32'h0000_0000;
      rctl_reg  <= 32'h0000_0000;
      rbuf_reg  <= 32'h0000_0000;
      rnext_reg <= 32'h0000_0000;
    end else if (mem_done) begin
      if (state_reg == MDF_TD1) tctl_reg  <= mem_rdata;
      if (state_reg == MDF_TD2) tbuf_reg  <= mem_rdata;
      if (state_reg == MDF_TD3) tnext_reg <= mem_rdata;
      if (state_reg == MDF_RD1) rctl_reg  <= mem_rdata;
      if (state_reg == MDF_RD2) rbuf_reg  <= mem_rdata;
      if (state_reg == MDF_RD3) rnext_reg <= mem_rdata;
    end
  end

  // Word counter and frame marks
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wcnt_reg   <= 10'h000;
      sum_on_reg <= 1'b0;
      rfirst_reg <= 1'b1;
    end else begin
      if ((state_reg == MDF_TD3 || state_reg == MDF_RD3) && mem_done)
        wcnt_reg <= 10'h000;
      else if (state_reg == MDF_TSUM && mem_done)
        wcnt_reg <= wcnt_reg == tlast_w ? 10'h000 : wcnt_reg + 10'h001;
      else if ((state_reg == MDF_TOUT && tx_valid_reg && tx_ready) ||
               (state_reg == MDF_RWR && mem_done))
        wcnt_reg <= wcnt_reg + 10'h001;
      // Later segments of a frame are never patched
      if (state_reg == MDF_TD3 && mem_done)
        sum_on_reg <= t_fs && (want_ip || want_tcp || want_udp);
      if (state_reg == MDF_RWB && mem_done)
        rfirst_reg <= rlast_reg;
    end
  end

  // Receive word capture
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rword_reg <= 32'h0000_0000;
      rlast_reg <= 1'b0;
    end else if (rx_take) begin
      rword_reg <= rx_data;
      rlast_reg <= rx_last;
    end
  end

  // Checksum pass accumulators
  always_ff @(posedge clock) begin
    if (sys_rst || (state_reg == MDF_TD3 && mem_done)) begin
      ipacc_reg  <= 32'h0000_0000;
      l4acc_reg  <= 32'h0000_0000;
      proto_reg  <= 8'h00;
      tlen_reg   <= 16'h0000;
      hdr_ok_reg <= 1'b0;
    end else if (state_reg == MDF_TSUM && mem_done) begin
      ipacc_reg <= ipacc_reg + ip_add;
      l4acc_reg <= l4acc_reg + l4_add;
      if (wcnt_reg == `MDF_ETYPE_WORD)
        hdr_ok_reg <= ha == `MDF_ETYPE_IPV4 && mem_rdata[23:16] == `MDF_VER_IHL_20;
      if (wcnt_reg == `MDF_TLEN_WORD) tlen_reg  <= ha;
      if (wcnt_reg == `MDF_PROTO_WORD) proto_reg <= mem_rdata[31:24];
    end
  end

  // Bus master and APB answer flops
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mem_req_reg   <= 1'b0;
      mem_we_reg    <= 1'b0;
      mem_addr_reg  <= 32'h0000_0000;
      mem_wdata_reg <= 32'h0000_0000;
      prdata_reg    <= 32'h0000_0000;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      // Request drops one cycle after each answer
      mem_req_reg   <= want_mem && !mem_done;
      mem_we_reg    <= is_write;
      mem_addr_reg  <= addr_mux;
      mem_wdata_reg <= wdata_mux;
      prdata_reg    <= setup_cyc ? rd_mux : prdata_reg;
      pready_reg    <= setup_cyc;
      pslverr_reg   <= setup_cyc && !mapped;
      irq_reg       <= |(stat_next & mask_reg);
    end
  end

  // Transmit stream and receive ready
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_data_reg  <= 32'h0000_0000;
      tx_valid_reg <= 1'b0;
      tx_sof_reg   <= 1'b0;
      tx_eof_reg   <= 1'b0;
      tx_bytes_reg <= 3'h0;
      tx_crc_reg   <= 1'b0;
      rx_ready_reg <= 1'b0;
    end else begin
      if (state_reg == MDF_TRD && mem_done) begin
        tx_data_reg  <= tx_word;
        tx_valid_reg <= 1'b1;
        tx_sof_reg   <= t_fs && wcnt_reg == 10'h000;
        tx_eof_reg   <= t_ls && wcnt_reg == tlast_w;
        tx_bytes_reg <= wcnt_reg == tlast_w ? last_bytes : 3'h4;
        if (t_fs && wcnt_reg == 10'h000)
          tx_crc_reg <= ctrl_reg[`MDF_CTRL_CRC];
      end else if (tx_ready) begin
        tx_valid_reg <= 1'b0;
      end
      // One word taken per visit to the input state
      rx_ready_reg <= state_reg == MDF_RIN && !rx_take;
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign mem_req       = mem_req_reg;
  assign mem_we        = mem_we_reg;
  assign mem_addr      = mem_addr_reg;
  assign mem_wdata     = mem_wdata_reg;
  assign tx_data       = tx_data_reg;
  assign tx_valid      = tx_valid_reg;
  assign tx_sof        = tx_sof_reg;
  assign tx_eof        = tx_eof_reg;
  assign tx_bytes      = tx_bytes_reg;
  assign tx_crc_append = tx_crc_reg;
  assign rx_ready      = rx_ready_reg;
  assign irq           = irq_reg;

endmodule // mdf_engine

// File: dv/mdf_engine_props.sv
// Port timing checker of the descriptor engine
`timescale 1ns/10ps
module mdf_engine_props (
  input wire logic        clock, sys_rst, psel, penable, pready, pslverr,
  input wire logic        mem_req, mem_ack, tx_valid, tx_ready, rx_valid, rx_ready,
  input wire logic [31:0] mem_addr, tx_data,
  input wire logic [2:0]  tx_bytes
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // APB setup cycle
  sequence s_setup; psel && !penable; endsequence
  // Memory access waiting for its answer
  sequence s_wait; mem_req && !mem_ack; endsequence
  AST_PREADY: assert property (s_setup |=> pready) else $error("no zero wait answer");
  AST_PONE: assert property (pready |-> penable ##1 !pready) else $error("pready too long");
  AST_SLVERR: assert property (pslverr |-> pready) else $error("pslverr alone");
  AST_MHOLD: assert property (s_wait |=> mem_req && $stable(mem_addr))
    else $error("req moved");
  AST_MGAP: assert property (mem_req && mem_ack |=> !mem_req) else $error("no gap");
  AST_ALIGN: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("unaligned");
  AST_TXHOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx word dropped");
  AST_BYTES: assert property (tx_valid |-> tx_bytes inside {[3'h1:3'h4]})
    else $error("lanes");
  AST_RXONE: assert property (rx_ready && rx_valid |=> !rx_ready) else $error("rx twice");
endmodule // mdf_engine_props
bind mdf_engine mdf_engine_props mdf_engine_props_i (.clock, .sys_rst, .psel, .penable,
  .pready, .pslverr, .mem_req, .mem_ack, .tx_valid, .tx_ready, .rx_valid, .rx_ready,
  .mem_addr, .tx_data, .tx_bytes);

// File: dv/mdf_mem_model.sv
// System memory holding descriptors and buffers, answering after three cycles
`timescale 1ns/10ps
module mdf_mem_model (
  input wire logic        clock, mem_req, mem_we,
  input wire logic [31:0] mem_addr, mem_wdata,
  output logic     [31:0] mem_rdata,
  output logic            mem_ack
);
  logic [31:0] m [0:255]; // Word store, host fills it
  logic [1:0]  cnt = 2'h0; // Latency counter
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0000_0000;
  // Read data toggles outside an answer so stale words never match
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h2) begin
        cnt <= 2'h0;
        mem_ack <= 1'b1;
        if (mem_we) m[mem_addr[9:2]] <= mem_wdata;
        else mem_rdata <= m[mem_addr[9:2]];
      end
    end
  end
endmodule // mdf_mem_model

// File: dv/mdf_engine_bench.sv
// Self-checking bench of the descriptor engine
`timescale 1ns/10ps
module mdf_engine_bench;
  logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic rx_valid = 0, rx_last = 0, tx_ready = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 0, rx_data = 0, rd, seed = 7, b0, b1, r0, r1, prdata, mem_addr;
  logic [31:0] mem_wdata, mem_rdata, tx_data;
  logic pready, pslverr, mem_req, mem_we, mem_ack, tx_valid, tx_sof, tx_eof;
  logic tx_crc_append, rx_ready, irq;
  logic [2:0] tx_bytes;
  logic [15:0] ck; // Expected IP header checksum
  logic [36:0] q[$]; // Accepted transmit words
  int num_errors = 0, check_count = 0, n;
  mdf_engine mdf_engine_i (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_ack, .tx_data, .tx_valid, .tx_sof, .tx_eof, .tx_bytes, .tx_crc_append, .tx_ready,
    .rx_data, .rx_valid, .rx_last, .rx_ready, .irq);
  mdf_mem_model mdf_mem_model_i (.clock, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed;
  endfunction
  // Ones complement sum of the 20-byte IPv4 header, checksum halfword skipped
  function automatic logic [15:0] ip_sum(input int w);
    logic [31:0] s, v;
    s = 0;
    for (int h = 7; h <= 16; h++) begin
      v = mdf_mem_model_i.m[w + h / 2];
      if (h != 12) s += (h % 2 == 1) ? {v[23:16], v[31:24]} : {v[7:0], v[15:8]};
    end
    s = s[15:0] + s[31:16];
    s = s[15:0] + s[31:16];
    return ~s[15:0];
  endfunction
  task test_done();
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic ok);
    check_count++;
    if (ok !== 1'b1) begin num_errors++; $display("BAD %0t mismatch %0d", $time, check_count); end
  endtask
  // APB transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock) penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask
  // One receive word, held until taken
  task rxw(input logic [31:0] d, input logic l);
    rx_valid <= 1'b1; rx_data <= d; rx_last <= l;
    do @(posedge clock); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0; rx_data <= ~d;
    @(posedge clock);
  endtask
  initial forever #20 clock = ~clock;
  initial begin repeat (20000) @(posedge clock); num_errors++; test_done(); end
  // Sink stalls at random
  always @(posedge clock) tx_ready <= rnd() > 32'h7FFF_FFFF;
  always @(posedge clock) if (tx_valid === 1'b1 && tx_ready === 1'b1)
    q.push_back({tx_sof, tx_eof, tx_bytes, tx_data});
  initial begin
    b0 = rnd(); b1 = rnd(); r0 = rnd(); r1 = rnd();
    mdf_mem_model_i.m[64] = 32'h8000_0000; mdf_mem_model_i.m[65] = 32'hE000_0008;
    mdf_mem_model_i.m[66] = 32'h0000_0200; mdf_mem_model_i.m[67] = 32'h0000_0110;
    mdf_mem_model_i.m[68] = 32'h0000_0000; mdf_mem_model_i.m[128] = b0;
    mdf_mem_model_i.m[129] = b1; mdf_mem_model_i.m[192] = 32'h8000_0000;
    mdf_mem_model_i.m[193] = 32'h0200_0008; mdf_mem_model_i.m[194] = 32'h0000_0380;
    mdf_mem_model_i.m[195] = 32'h0000_03F0;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    apb(0, 8'h10, 0); chk(rd === 0 && er === 1'b0);
    apb(1, 8'h10, 3); apb(1, 8'h04, 32'h100); apb(1, 8'h08, 32'h300); apb(1, 8'h00, 32'h13);
    apb(1, 8'h14, 1); n = 0;
    while ((irq !== 1'b1 || mdf_mem_model_i.m[64] !== 0) && n < 3000) begin
      @(posedge clock); n++;
    end
    chk(mdf_mem_model_i.m[64] === 32'h0);
    chk(q.size() == 2 && q[0] === {5'h14, b0});
    chk(q[1] === {5'h0C, b1});
    chk(tx_crc_append === 1'b1);
    apb(0, 8'h0C, 0); chk(rd[0] === 1'b1 && irq === 1'b1);
    apb(1, 8'h0C, 5); apb(0, 8'h0C, 0); chk(rd[0] === 1'b0 && irq === 1'b0);
    apb(0, 8'h24, 0); chk(er === 1'b1 && rd === 0);
    rxw(r0, 1'b0); rxw(r1, 1'b1); n = 0;
    while (mdf_mem_model_i.m[192] === 32'h8000_0000 && n < 500) begin @(posedge clock); n++; end
    repeat (4) @(posedge clock);
    chk(mdf_mem_model_i.m[192] === 32'h6000_0008);
    chk(mdf_mem_model_i.m[224] === r0 && mdf_mem_model_i.m[225] === r1);
    apb(0, 8'h1C, 0); chk(rd === 32'h300);
    // Single-buffer IPv4 frame of 40 bytes with the per-descriptor IP sum bit
    for (int i = 160; i < 170; i++) mdf_mem_model_i.m[i] = rnd();
    mdf_mem_model_i.m[163][23:0] = 24'h45_0008; // Ethertype IPv4, plain 20-byte header
    mdf_mem_model_i.m[68] = 32'h8000_0000; mdf_mem_model_i.m[69] = 32'h7000_0028;
    mdf_mem_model_i.m[70] = 32'h0000_0280; mdf_mem_model_i.m[71] = 32'h0000_0100;
    ck = ip_sum(160); n = 0;
    apb(1, 8'h14, 1);
    while (q.size() < 12 && n < 3000) begin @(posedge clock); n++; end
    chk(q.size() == 12 && q[8] === {5'h04, mdf_mem_model_i.m[166][31:16], ck[7:0], ck[15:8]});
    chk(q[2] === {5'h14, mdf_mem_model_i.m[160]} && q[11] === {5'h0C, mdf_mem_model_i.m[169]});
    test_done();
  end
endmodule // mdf_engine_bench
